/* core/sorm_pkg.sv */
// Package: register map and constants for the status output row mux
package sorm_pkg;
    // ==========================================
    // Register offsets (byte addresses)
    localparam logic [11:0] SORM_ROW_SELECT_OFFSET = 12'h0D4;
    localparam logic [11:0] SORM_PIN_MASK_OFFSET = 12'h0D8;
    localparam logic [11:0] SORM_IRQ_STATUS_OFFSET = 12'h100;
    localparam logic [11:0] SORM_IRQ_MASK_OFFSET = 12'h104;
    // Printed register indices
    localparam logic [9:0] SORM_ROW_SELECT_INDEX = 10'h035;
    localparam logic [9:0] SORM_PIN_MASK_INDEX = 10'h036;
    // ==========================================
    // Reset values
    localparam logic [7:0] SORM_ROW_SELECT_RESET = 8'h00;
    localparam logic [7:0] SORM_PIN_MASK_RESET = 8'hFF;
    localparam logic [7:0] SORM_IRQ_MASK_RESET = 8'h00;
    // ==========================================
    // Row codes
    localparam logic [7:0] SORM_ROW_CAL = 8'h00;
    localparam logic [7:0] SORM_ROW_LOCK = 8'h01;
    localparam logic [7:0] SORM_ROW_BUSY = 8'h02;
    localparam logic [7:0] SORM_ROW_GAIN_A = 8'h05;
    localparam logic [7:0] SORM_ROW_GAIN_B = 8'h08;
    localparam logic [7:0] SORM_ROW_AUX = 8'h1E;
    // ==========================================
    // Bus responses
    localparam logic [1:0] SORM_RESP_OKAY = 2'h0;
    localparam logic [1:0] SORM_RESP_SLVERR = 2'h2;
endpackage

/* core/sorm_top.sv */
// Status output row mux with AXI4-Lite register slave
//
// Contract
// - Eight dedicated status pins carry internal status, registered one clock behind the sources.
// - Row select register picks the displayed row; resets to row zero.
// - Each pin mask bit independently enables its pin.
// - Pins with cleared mask bit are driven low.
// - Only one row is visible on the pins at a time.
// - Row 0x08 shows gain-changed on D4, mask 0x10.
// - Gain-changed also on D6 in row 0x05 and D2 in row 0x1E.
// - Row 0x1E carries aux converter word-valid on D0.
// - Pin mask holds eight enables and resets to all ones.
// - Row 00 shows cal-complete flags on D7 down to D4.
// - Row 01 shows tx, rx and bb synth lock on D7..D5.
// - Row 02 shows four calibration-active flags on D7..D4.
`timescale 1ns/1ps
module sorm_top (
    // Clock, reset, enable
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic ce_in,
    // Row 00 sources
    input wire logic calib_all_complete_in,
    input wire logic tx_pump_cal_complete_in,
    input wire logic rx_pump_cal_complete_in,
    input wire logic rx_bb_filter_tune_complete_in,
    // Row 01 sources
    input wire logic tx_synth_locked_in,
    input wire logic rx_synth_locked_in,
    input wire logic bb_synth_locked_in,
    // Row 02 sources
    input wire logic bb_dc_cal_active_in,
    input wire logic rf_dc_cal_active_in,
    input wire logic rx_quad_cal_active_in,
    input wire logic tx_quad_cal_active_in,
    // Rows 05, 08 and 1E sources
    input wire logic rx_gain_changed_in,
    input wire logic aux_word_valid_in,
    // Status pins
    output logic [7:0] status_pins_out,
    // Interrupt
    output logic irq_out,
    // AXI4-Lite write address
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // AXI4-Lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read address
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    // ==========================================
    // Registers
    logic [7:0] row_select_reg;
    logic [7:0] pin_mask_reg;
    logic [7:0] irq_status_reg;
    logic [7:0] irq_mask_reg;
    logic [7:0] pins_reg;
    logic [7:0] pins_prev_reg;
    logic aw_held_reg;
    logic w_held_reg;
    logic [11:0] awaddr_reg;
    logic [31:0] wdata_reg;
    logic [3:0] wstrb_reg;
    logic bvalid_reg;
    logic [1:0] bresp_reg;
    logic rvalid_reg;
    logic [31:0] rdata_reg;
    logic [1:0] rresp_reg;

    // ==========================================
    // Row content
    logic [7:0] row_cal;
    logic [7:0] row_lock;
    logic [7:0] row_busy;
    logic [7:0] row_gain_a;
    logic [7:0] row_gain_b;
    logic [7:0] row_aux;
    logic [7:0] row_value;
    logic [7:0] pins_next;

    assign row_cal = {calib_all_complete_in, tx_pump_cal_complete_in,
        rx_pump_cal_complete_in, rx_bb_filter_tune_complete_in, 4'h0};
    assign row_lock = {tx_synth_locked_in, rx_synth_locked_in,
        bb_synth_locked_in, 5'h00};
    assign row_busy = {bb_dc_cal_active_in, rf_dc_cal_active_in,
        rx_quad_cal_active_in, tx_quad_cal_active_in, 4'h0};
    assign row_gain_a = {1'b0, rx_gain_changed_in, 6'h00};
    assign row_gain_b = {3'h0, rx_gain_changed_in, 4'h0};
    assign row_aux = {5'h00, rx_gain_changed_in, 1'b0, aux_word_valid_in};

    // Single selector: one row visible at a time, others fall to zero
    assign row_value =
        (row_select_reg == sorm_pkg::SORM_ROW_CAL) ? row_cal :
        (row_select_reg == sorm_pkg::SORM_ROW_LOCK) ? row_lock :
        (row_select_reg == sorm_pkg::SORM_ROW_BUSY) ? row_busy :
        (row_select_reg == sorm_pkg::SORM_ROW_GAIN_A) ? row_gain_a :
        (row_select_reg == sorm_pkg::SORM_ROW_GAIN_B) ? row_gain_b :
        (row_select_reg == sorm_pkg::SORM_ROW_AUX) ? row_aux :
        8'h00;
    assign pins_next = row_value & pin_mask_reg;
    assign status_pins_out = pins_reg;

    // ==========================================
    // Bus decode
    logic do_write;
    logic [11:0] wr_addr;
    logic [31:0] wr_data;
    logic wr_lane0;
    logic wr_row_sel;
    logic wr_pin_mask;
    logic wr_irq_status;
    logic wr_irq_mask;
    logic wr_hit;
    logic do_read;
    logic rd_hit;
    logic [7:0] rd_byte;
    logic [7:0] rise_events;
    logic [7:0] irq_status_next;

    assign wr_addr = s_axi_awvalid && !aw_held_reg ? s_axi_awaddr : awaddr_reg;
    assign wr_data = s_axi_wvalid && !w_held_reg ? s_axi_wdata : wdata_reg;
    assign wr_lane0 = s_axi_wvalid && !w_held_reg ? s_axi_wstrb[0] : wstrb_reg[0];
    assign do_write = (aw_held_reg || s_axi_awvalid) && (w_held_reg || s_axi_wvalid)
        && !bvalid_reg && ce_in;
    assign s_axi_awready = !aw_held_reg && !bvalid_reg && ce_in;
    assign s_axi_wready = !w_held_reg && !bvalid_reg && ce_in;
    assign wr_row_sel = do_write && wr_lane0
        && wr_addr == sorm_pkg::SORM_ROW_SELECT_OFFSET;
    assign wr_pin_mask = do_write && wr_lane0
        && wr_addr == sorm_pkg::SORM_PIN_MASK_OFFSET;
    assign wr_irq_status = do_write && wr_lane0
        && wr_addr == sorm_pkg::SORM_IRQ_STATUS_OFFSET;
    assign wr_irq_mask = do_write && wr_lane0
        && wr_addr == sorm_pkg::SORM_IRQ_MASK_OFFSET;
    assign wr_hit = wr_addr == sorm_pkg::SORM_ROW_SELECT_OFFSET
        || wr_addr == sorm_pkg::SORM_PIN_MASK_OFFSET
        || wr_addr == sorm_pkg::SORM_IRQ_STATUS_OFFSET
        || wr_addr == sorm_pkg::SORM_IRQ_MASK_OFFSET;

    assign s_axi_arready = !rvalid_reg && ce_in;
    assign do_read = s_axi_arvalid && s_axi_arready;
    assign rd_hit = s_axi_araddr == sorm_pkg::SORM_ROW_SELECT_OFFSET
        || s_axi_araddr == sorm_pkg::SORM_PIN_MASK_OFFSET
        || s_axi_araddr == sorm_pkg::SORM_IRQ_STATUS_OFFSET
        || s_axi_araddr == sorm_pkg::SORM_IRQ_MASK_OFFSET;
    assign rd_byte =
        (s_axi_araddr == sorm_pkg::SORM_ROW_SELECT_OFFSET) ? row_select_reg :
        (s_axi_araddr == sorm_pkg::SORM_PIN_MASK_OFFSET) ? pin_mask_reg :
        (s_axi_araddr == sorm_pkg::SORM_IRQ_STATUS_OFFSET) ? irq_status_reg :
        (s_axi_araddr == sorm_pkg::SORM_IRQ_MASK_OFFSET) ? irq_mask_reg :
        8'h00;

    // Events are rising edges of the presented pins; set beats clear
    assign rise_events = pins_reg & ~pins_prev_reg;
    assign irq_status_next = (irq_status_reg & ~(wr_irq_status ? wr_data[7:0] : 8'h00))
        | rise_events;

    assign irq_out = |(irq_status_reg & irq_mask_reg);
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata = rdata_reg;
    assign s_axi_rresp = rresp_reg;

    // ==========================================
    // Control registers
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            row_select_reg <= sorm_pkg::SORM_ROW_SELECT_RESET;
            pin_mask_reg <= sorm_pkg::SORM_PIN_MASK_RESET;
            irq_mask_reg <= sorm_pkg::SORM_IRQ_MASK_RESET;
            irq_status_reg <= 8'h00;
            pins_reg <= 8'h00;
            pins_prev_reg <= 8'h00;
        end else if (ce_in) begin
            if (wr_row_sel) begin
                row_select_reg <= wr_data[7:0];
            end
            if (wr_pin_mask) begin
                pin_mask_reg <= wr_data[7:0];
            end
            if (wr_irq_mask) begin
                irq_mask_reg <= wr_data[7:0];
            end
            irq_status_reg <= irq_status_next;
            pins_reg <= pins_next;
            pins_prev_reg <= pins_reg;
        end
    end

    // ==========================================
    // Write channel
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            awaddr_reg <= 12'h000;
            wdata_reg <= 32'h0000_0000;
            wstrb_reg <= 4'h0;
            bvalid_reg <= 1'b0;
            bresp_reg <= sorm_pkg::SORM_RESP_OKAY;
        end else if (ce_in) begin
            if (do_write) begin
                aw_held_reg <= 1'b0;
                w_held_reg <= 1'b0;
                bvalid_reg <= 1'b1;
                bresp_reg <= wr_hit ? sorm_pkg::SORM_RESP_OKAY : sorm_pkg::SORM_RESP_SLVERR;
            end else begin
                if (s_axi_awvalid && s_axi_awready) begin
                    aw_held_reg <= 1'b1;
                    awaddr_reg <= s_axi_awaddr;
                end
                if (s_axi_wvalid && s_axi_wready) begin
                    w_held_reg <= 1'b1;
                    wdata_reg <= s_axi_wdata;
                    wstrb_reg <= s_axi_wstrb;
                end
                if (bvalid_reg && s_axi_bready) begin
                    bvalid_reg <= 1'b0;
                end
            end
        end
    end

    // ==========================================
    // Read channel
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
            rresp_reg <= sorm_pkg::SORM_RESP_OKAY;
        end else if (ce_in) begin
            if (do_read) begin
                rvalid_reg <= 1'b1;
                rdata_reg <= {24'h000000, rd_byte};
                rresp_reg <= rd_hit ? sorm_pkg::SORM_RESP_OKAY : sorm_pkg::SORM_RESP_SLVERR;
            end else if (rvalid_reg && s_axi_rready) begin
                rvalid_reg <= 1'b0;
            end
        end
    end
endmodule

/* testbench/sorm_monitor.sv */
// Assertion checker for the status row mux pins and register bus
`timescale 1ns/1ps
module sorm_monitor (
    // Clock, reset, enable
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic ce_in,
    // Sources and pins
    input wire logic calib_all_complete_in,
    input wire logic tx_pump_cal_complete_in,
    input wire logic rx_bb_filter_tune_complete_in,
    input wire logic tx_synth_locked_in,
    input wire logic rx_synth_locked_in,
    input wire logic bb_dc_cal_active_in,
    input wire logic rf_dc_cal_active_in,
    input wire logic tx_quad_cal_active_in,
    input wire logic rx_gain_changed_in,
    input wire logic aux_word_valid_in,
    input wire logic [7:0] status_pins_out,
    // Bus handshakes
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid
);
    // ==========================================
    // Properties
    default clocking @(posedge clk_in); endclocking
    default disable iff (rst_in);
    chk_spare_low: assert property (!status_pins_out[3] && !status_pins_out[1])
        else $error("spare pin driven high");
    // Frozen cycles skipped, pins then hold an older row
    chk_aux_d0: assert property ($past(ce_in) && status_pins_out[0] |-> $past(aux_word_valid_in))
        else $error("pin D0 high without word valid");
    chk_gain_d2: assert property ($past(ce_in) && status_pins_out[2] |-> $past(rx_gain_changed_in))
        else $error("pin D2 high without gain change");
    chk_d4_source: assert property ($past(ce_in) && status_pins_out[4] |-> $past(rx_gain_changed_in)
        || $past(rx_bb_filter_tune_complete_in) || $past(tx_quad_cal_active_in))
        else $error("pin D4 high without source");
    chk_d6_source: assert property ($past(ce_in) && status_pins_out[6] |-> $past(rx_gain_changed_in)
        || $past(tx_pump_cal_complete_in) || $past(rx_synth_locked_in)
        || $past(rf_dc_cal_active_in))
        else $error("pin D6 high without source");
    chk_d7_source: assert property ($past(ce_in) && status_pins_out[7] |-> $past(calib_all_complete_in)
        || $past(tx_synth_locked_in) || $past(bb_dc_cal_active_in))
        else $error("pin D7 high without source");
    chk_wr_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |=> s_axi_bvalid)
        else $error("write response missing");
    chk_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read response missing");
    chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped early");
    cover property (status_pins_out[2] && status_pins_out[0]);
    cover property (s_axi_bvalid && s_axi_bready);
    cover property (status_pins_out[7]);
endmodule
bind sorm_top sorm_monitor sorm_monitor_i (.*);

/* testbench/sorm_host_model.sv */
// Baseband host model sampling the status pins
`timescale 1ns/1ps
module sorm_host_model (
    // Clock and pins
    input wire logic clk_in,
    input wire logic [7:0] status_pins_in,
    // Last sampled pin word
    output logic [7:0] seen_out
);
    // Host input register, one edge behind the pins
    always_ff @(posedge clk_in) begin
        seen_out <= status_pins_in;
    end
endmodule

/* testbench/tb_top.sv */
// Self-checking bench for the status output row mux
`timescale 1ns/1ps
module tb_top;
    // ==========================================
    // Signals
    logic clk_in, rst_in = 1'h1, ce_in = 1'h1, irq_out;
    logic [12:0] src = 13'h0;
    logic [7:0] status_pins_out, seen;
    logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp;
    logic [7:0] rows [8] = '{8'h00, 8'h01, 8'h02, 8'h05, 8'h08, 8'h1E, 8'h03, 8'hFF};
    int errors = 0, n_compared = 0;
    sorm_top sorm_top_i (
        .calib_all_complete_in(src[12]),
        .tx_pump_cal_complete_in(src[11]),
        .rx_pump_cal_complete_in(src[10]),
        .rx_bb_filter_tune_complete_in(src[9]),
        .tx_synth_locked_in(src[8]),
        .rx_synth_locked_in(src[7]),
        .bb_synth_locked_in(src[6]),
        .bb_dc_cal_active_in(src[5]),
        .rf_dc_cal_active_in(src[4]),
        .rx_quad_cal_active_in(src[3]),
        .tx_quad_cal_active_in(src[2]),
        .rx_gain_changed_in(src[1]),
        .aux_word_valid_in(src[0]),
        .*
    );
    sorm_host_model sorm_host_model_i (.clk_in(clk_in), .status_pins_in(status_pins_out),
        .seen_out(seen));
    // ==========================================
    // Tasks
    function automatic logic [7:0] rowv(input logic [7:0] s, input logic [12:0] v);
        case (s)
            8'h00: return {v[12:9], 4'h0};
            8'h01: return {v[8:6], 5'h0};
            8'h02: return {v[5:2], 4'h0};
            8'h05: return {1'h0, v[1], 6'h0};
            8'h08: return {3'h0, v[1], 4'h0};
            8'h1E: return {5'h0, v[1], 1'h0, v[0]};
            default: return 8'h00;
        endcase
    endfunction
    task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d, output logic [1:0] r);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        do begin
            @(posedge clk_in);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
        end while (s_axi_awvalid && !s_axi_awready || s_axi_wvalid && !s_axi_wready);
        // Late bready so the slave has to hold its answer
        @(posedge clk_in);
        s_axi_bready <= 1'h1;
        do @(posedge clk_in); while (!s_axi_bvalid);
        r = s_axi_bresp;
        s_axi_bready <= 1'h0;
    endtask
    task automatic rd_reg(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do @(posedge clk_in); while (!s_axi_arready);
        s_axi_arvalid <= 1'h0;
        do @(posedge clk_in); while (!s_axi_rvalid);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'h0;
    endtask
    task automatic pin_chk(input logic [7:0] sel, input logic [7:0] mask, input logic [12:0] v);
        wr(sorm_pkg::SORM_ROW_SELECT_OFFSET, sel, resp);
        wr(sorm_pkg::SORM_PIN_MASK_OFFSET, mask, resp);
        src <= v;
        repeat (3) @(posedge clk_in);
        cmp("pins", {24'h0, rowv(sel, v) & mask}, {24'h0, seen});
    endtask
    task automatic summarize;
        $display("compared %0d mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // ==========================================
    // Clock, watchdog, tests
    initial begin
        clk_in = 1'h0;
        forever #10 clk_in = ~clk_in;
    end
    initial begin
        repeat (20000) @(posedge clk_in);
        errors++;
        summarize();
    end
    initial begin
        repeat (2) @(posedge clk_in);
        rst_in <= 1'h0;
        rd_reg(sorm_pkg::SORM_ROW_SELECT_OFFSET, rd, resp);
        cmp("row select reset", 32'h0, rd);
        rd_reg(sorm_pkg::SORM_PIN_MASK_OFFSET, rd, resp);
        cmp("pin mask reset", 32'hFF, rd);
        foreach (rows[i]) begin
            pin_chk(rows[i], 8'hFF, 13'h1FFF);
            pin_chk(rows[i], 8'hFF, 13'h0AAA);
            pin_chk(rows[i], 8'hFF, 13'h1555);
        end
        pin_chk(8'h1E, 8'h05, 13'h0003);
        pin_chk(8'h1E, 8'h04, 13'h0003);
        pin_chk(8'h05, 8'h40, 13'h1FFF);
        pin_chk(8'h08, 8'h10, 13'h1FFF);
        pin_chk(8'h00, 8'hA5, 13'h1FFF);
        cmp("mapped write resp", 32'h0, {30'h0, resp});
        rd_reg(sorm_pkg::SORM_PIN_MASK_OFFSET, rd, resp);
        cmp("mask readback", 32'hA5, rd);
        wr(12'h0C0, 8'h12, resp);
        cmp("unmapped write resp", 32'h2, {30'h0, resp});
        rd_reg(12'h0C0, rd, resp);
        cmp("unmapped read resp", 32'h2, {30'h0, resp});
        pin_chk(8'h08, 8'hFF, 13'h0000);
        wr(sorm_pkg::SORM_IRQ_STATUS_OFFSET, 8'hFF, resp);
        wr(sorm_pkg::SORM_IRQ_MASK_OFFSET, 8'h10, resp);
        cmp("irq idle", 32'h0, {31'h0, irq_out});
        src <= 13'h0002;
        repeat (3) @(posedge clk_in);
        cmp("irq raised", 32'h1, {31'h0, irq_out});
        rd_reg(sorm_pkg::SORM_IRQ_STATUS_OFFSET, rd, resp);
        cmp("irq status", 32'h10, rd);
        wr(sorm_pkg::SORM_IRQ_MASK_OFFSET, 8'h00, resp);
        cmp("irq masked", 32'h0, {31'h0, irq_out});
        wr(sorm_pkg::SORM_IRQ_STATUS_OFFSET, 8'h10, resp);
        wr(sorm_pkg::SORM_IRQ_MASK_OFFSET, 8'h10, resp);
        cmp("irq cleared", 32'h0, {31'h0, irq_out});
        // Enable low freezes the pins at their last row value
        ce_in <= 1'h0;
        src <= 13'h0000;
        repeat (3) @(posedge clk_in);
        cmp("pins frozen", 32'h10, {24'h0, seen});
        ce_in <= 1'h1;
        repeat (3) @(posedge clk_in);
        cmp("pins resumed", 32'h0, {24'h0, seen});
        summarize();
    end
endmodule
